//--- rtl/dld_top.sv
// Frequency and current level detectors with AXI4-Lite settings
`timescale 1ns/1ns
`default_nettype none
module dld_top
  import dld_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DLD_TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] ramp_freq,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] out_current,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic running,
  input wire logic motor_one_active,
  input wire logic ramp_by_terminal,
  input wire logic jog_request,
  output logic [15:0] run_freq_q,
  output dld_stat_t stat_q
);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] pct);
    logic [31:0] prod;
    prod = ({16'h0000, base} * {16'h0000, pct}) / DLD_PCT_FULL;
    pct_of = (prod > 32'h0000_FFFF) ? 16'hFFFF : prod[15:0];
  endfunction : pct_of

  function automatic logic in_band(input logic [15:0] val, input logic [15:0] ctr,
                                   input logic [15:0] width);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = ({1'b0, ctr} > {1'b0, width}) ? ({1'b0, ctr} - {1'b0, width}) : 17'h00000;
    hi = {1'b0, ctr} + {1'b0, width};
    in_band = ({1'b0, val} >= lo) && ({1'b0, val} <= hi);
  endfunction : in_band

  function automatic logic fdt_next(input logic cur, input logic [15:0] f,
                                    input logic [15:0] lvl, input logic [15:0] hyst);
    logic [15:0] off_lvl;
    off_lvl = (lvl > hyst) ? (lvl - hyst) : 16'h0000;
    if (f > lvl)
    begin
      fdt_next = 1'b1;
    end
    else if (f < off_lvl)
    begin
      fdt_next = 1'b0;
    end
    else
    begin
      fdt_next = cur;
    end
  endfunction : fdt_next

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [15:0] cfg_q [DLD_NREG];
  logic [15:0] cfg_d [DLD_NREG];
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [4:0] w_idx;
  logic [5:0] r_idx;

  always_comb
  begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    cfg_d = cfg_q;
    w_idx = aw_addr_q[6:2];
    r_idx = s_axi_araddr[7:2];
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !s_axi_bvalid)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      // Only the low 16 bits hold settings; upper lanes are dropped
      if (aw_addr_q[7] == 1'b0 && int'(w_idx) < DLD_NREG)
      begin
        bresp_d = DLD_RESP_OKAY;
        if (w_strb_q[0])
        begin
          cfg_d[w_idx][7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1])
        begin
          cfg_d[w_idx][15:8] = w_data_q[15:8];
        end
      end
      else
      begin
        bresp_d = DLD_RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = DLD_RESP_OKAY;
      if (int'(r_idx) < DLD_NREG)
      begin
        rdata_d = {16'h0000, cfg_q[r_idx[4:0]]};
      end
      else if (s_axi_araddr[7:2] == DLD_OFF_STATUS[7:2])
      begin
        rdata_d = {20'h00000, stat_q};
      end
      else
      begin
        rdata_d = 32'h0000_0000;
        rresp_d = DLD_RESP_SLVERR;
      end
    end
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      for (int i = 0; i < DLD_NREG; i++)
      begin
        cfg_q[i] <= dld_reset_value(i);
      end
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Settings and derived thresholds
  // ----------------------------------------------------------------
  logic jump_ramp_en, jog_prio, ramp_sel_en;
  logic [15:0] max_freq, hys1_amt, hys2_amt, jband;
  logic tgt_in, arr1_in, arr2_in, cur1_in, cur2_in;
  logic zero_cond, oc_cond;

  assign jump_ramp_en = cfg_q[DLD_OFF_CTRL[6:2]][DLD_CTRL_JUMP_RAMP];
  assign jog_prio = cfg_q[DLD_OFF_CTRL[6:2]][DLD_CTRL_JOG_PRIO];
  assign max_freq = cfg_q[DLD_OFF_MAX_FREQ[6:2]];
  assign jband = cfg_q[DLD_OFF_JUMP_BAND[6:2]];
  assign hys1_amt = pct_of(cfg_q[DLD_OFF_LVL1_LEVEL[6:2]], cfg_q[DLD_OFF_LVL1_HYST[6:2]]);
  assign hys2_amt = pct_of(cfg_q[DLD_OFF_LVL2_LEVEL[6:2]], cfg_q[DLD_OFF_LVL2_HYST[6:2]]);
  assign tgt_in = in_band(run_freq_q, target_freq,
                          pct_of(max_freq, cfg_q[DLD_OFF_TGT_WIDTH[6:2]]));
  assign arr1_in = in_band(run_freq_q, cfg_q[DLD_OFF_ARR1_FREQ[6:2]],
                           pct_of(max_freq, cfg_q[DLD_OFF_ARR1_WIDTH[6:2]]));
  assign arr2_in = in_band(run_freq_q, cfg_q[DLD_OFF_ARR2_FREQ[6:2]],
                           pct_of(max_freq, cfg_q[DLD_OFF_ARR2_WIDTH[6:2]]));
  assign cur1_in = in_band(out_current, cfg_q[DLD_OFF_CUR1_LEVEL[6:2]],
                           cfg_q[DLD_OFF_CUR1_WIDTH[6:2]]);
  assign cur2_in = in_band(out_current, cfg_q[DLD_OFF_CUR2_LEVEL[6:2]],
                           cfg_q[DLD_OFF_CUR2_WIDTH[6:2]]);
  assign zero_cond = out_current <= cfg_q[DLD_OFF_ZERO_LEVEL[6:2]];
  assign oc_cond = (cfg_q[DLD_OFF_OC_LEVEL[6:2]] != 16'h0000) &&
                   (out_current >= cfg_q[DLD_OFF_OC_LEVEL[6:2]]);
  assign ramp_sel_en = motor_one_active && !ramp_by_terminal;

  // ----------------------------------------------------------------
  // Delay tick and current timers
  // ----------------------------------------------------------------
  logic [31:0] pre_q, pre_d;
  logic tick_q, tick_d, zero_act, oc_act;

  always_comb
  begin
    tick_d = (pre_q == TICK_CYCLES - 1);
    pre_d = tick_d ? 32'h0000_0000 : pre_q + 32'h0000_0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      tick_q <= tick_d;
    end
  end

  dld_delay_timer u_zero_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .cond(zero_cond),
    .delay(cfg_q[DLD_OFF_ZERO_DELAY[6:2]]),
    .active_q(zero_act)
  );

  dld_delay_timer u_oc_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_q),
    .cond(oc_cond),
    .delay(cfg_q[DLD_OFF_OC_DELAY[6:2]]),
    .active_q(oc_act)
  );

  // ----------------------------------------------------------------
  // Running frequency with jump bands, and detector outputs
  // ----------------------------------------------------------------
  logic [15:0] run_freq_d;
  dld_stat_t stat_d;

  always_comb
  begin
    logic [15:0] jp;
    logic [16:0] hi;
    jp = 16'h0000;
    hi = 17'h00000;
    run_freq_d = ramp_freq;
    // Two jump points share one band; a zero point is unused
    for (int k = 0; k < 2; k++)
    begin
      jp = (k == 0) ? cfg_q[DLD_OFF_JUMP1[6:2]] : cfg_q[DLD_OFF_JUMP2[6:2]];
      hi = {1'b0, jp} + {1'b0, jband};
      if (jump_ramp_en && jp != 16'h0000 &&
          ramp_freq > ((jp > jband) ? jp - jband : 16'h0000) && {1'b0, ramp_freq} < hi)
      begin
        if (accelerating)
        begin
          run_freq_d = hi[16] ? 16'hFFFF : hi[15:0];
        end
        else if (decelerating)
        begin
          run_freq_d = (jp > jband) ? jp - jband : 16'h0000;
        end
      end
    end
    stat_d.freq_level_detector_one = fdt_next(stat_q.freq_level_detector_one, run_freq_q,
      cfg_q[DLD_OFF_LVL1_LEVEL[6:2]], hys1_amt);
    stat_d.freq_level_detector_two = fdt_next(stat_q.freq_level_detector_two, run_freq_q,
      cfg_q[DLD_OFF_LVL2_LEVEL[6:2]], hys2_amt);
    stat_d.target = tgt_in;
    stat_d.arr1 = arr1_in;
    stat_d.arr2 = arr2_in;
    stat_d.zero_cur = zero_act;
    stat_d.over_cur = oc_act;
    stat_d.cur_arr1 = cur1_in;
    stat_d.cur_arr2 = cur2_in;
    stat_d.accel_two = ramp_sel_en && (run_freq_q < cfg_q[DLD_OFF_ACCEL_SW[6:2]]);
    stat_d.decel_two = ramp_sel_en && !(run_freq_q > cfg_q[DLD_OFF_DECEL_SW[6:2]]);
    // Without priority a terminal jog is only honoured while stopped
    stat_d.jog = jog_request && (!running || jog_prio);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_freq_q <= 16'h0000;
      stat_q <= '0;
    end
    else
    begin
      run_freq_q <= run_freq_d;
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fdt_rise_on: assert property ((run_freq_q > cfg_q[DLD_OFF_LVL1_LEVEL[6:2]])
    |=> stat_q.freq_level_detector_one) else $error("level detector one not on above level");
  a_fdt_fall_off: assert property (
    (run_freq_q < cfg_q[DLD_OFF_LVL1_LEVEL[6:2]] - hys1_amt &&
    cfg_q[DLD_OFF_LVL1_LEVEL[6:2]] > hys1_amt) |=> !stat_q.freq_level_detector_one)
    else $error("level detector one not off below threshold");
  // Gated by reset so the cycle of release, still held in reset, is not compared
  a_target_band: assert property (aresetn |=> (stat_q.target == $past(tgt_in)))
    else $error("target arrival does not follow band");
  a_jump_off: assert property (!jump_ramp_en |=> (run_freq_q == $past(ramp_freq)))
    else $error("frequency altered with jump disabled");
  a_accel_select: assert property (
    (ramp_sel_en && run_freq_q < cfg_q[DLD_OFF_ACCEL_SW[6:2]]) |=> stat_q.accel_two)
    else $error("accel time two not selected");
  a_decel_select: assert property ((run_freq_q > cfg_q[DLD_OFF_DECEL_SW[6:2]])
    |=> !stat_q.decel_two) else $error("decel time one not selected");
  a_ramp_gate: assert property (!ramp_sel_en |=> (!stat_q.accel_two && !stat_q.decel_two))
    else $error("ramp selection active outside motor one");
  a_jog_priority: assert property ((jog_prio && running && jog_request) |=> stat_q.jog)
    else $error("jog priority ignored");
  a_oc_disabled: assert property ((cfg_q[DLD_OFF_OC_LEVEL[6:2]] == 16'h0000)[*2]
    |=> !stat_q.over_cur) else $error("over current with zero threshold");
  a_cur_band: assert property (aresetn |=> (stat_q.cur_arr1 == $past(cur1_in)))
    else $error("current arrival does not follow band");

endmodule : dld_top
`default_nettype wire

//--- rtl/dld_pkg.sv
// Package of constants and types for the drive level detectors
package dld_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets, one aligned word each)
  // ----------------------------------------------------------------
  localparam int DLD_NREG = 24;
  localparam logic [7:0] DLD_OFF_CTRL = 8'h00;
  localparam logic [7:0] DLD_OFF_MAX_FREQ = 8'h04;
  localparam logic [7:0] DLD_OFF_LVL1_LEVEL = 8'h08;
  localparam logic [7:0] DLD_OFF_LVL1_HYST = 8'h0C;
  localparam logic [7:0] DLD_OFF_LVL2_LEVEL = 8'h10;
  localparam logic [7:0] DLD_OFF_LVL2_HYST = 8'h14;
  localparam logic [7:0] DLD_OFF_TGT_WIDTH = 8'h18;
  localparam logic [7:0] DLD_OFF_ARR1_FREQ = 8'h1C;
  localparam logic [7:0] DLD_OFF_ARR1_WIDTH = 8'h20;
  localparam logic [7:0] DLD_OFF_ARR2_FREQ = 8'h24;
  localparam logic [7:0] DLD_OFF_ARR2_WIDTH = 8'h28;
  localparam logic [7:0] DLD_OFF_ZERO_LEVEL = 8'h2C;
  localparam logic [7:0] DLD_OFF_ZERO_DELAY = 8'h30;
  localparam logic [7:0] DLD_OFF_OC_LEVEL = 8'h34;
  localparam logic [7:0] DLD_OFF_OC_DELAY = 8'h38;
  localparam logic [7:0] DLD_OFF_CUR1_LEVEL = 8'h3C;
  localparam logic [7:0] DLD_OFF_CUR1_WIDTH = 8'h40;
  localparam logic [7:0] DLD_OFF_CUR2_LEVEL = 8'h44;
  localparam logic [7:0] DLD_OFF_CUR2_WIDTH = 8'h48;
  localparam logic [7:0] DLD_OFF_ACCEL_SW = 8'h4C;
  localparam logic [7:0] DLD_OFF_DECEL_SW = 8'h50;
  localparam logic [7:0] DLD_OFF_JUMP1 = 8'h54;
  localparam logic [7:0] DLD_OFF_JUMP2 = 8'h58;
  localparam logic [7:0] DLD_OFF_JUMP_BAND = 8'h5C;
  localparam logic [7:0] DLD_OFF_STATUS = 8'h60;

  // ----------------------------------------------------------------
  // Control fields and scaling (0.01 Hz, 0.1 %, 10 ms units)
  // ----------------------------------------------------------------
  localparam int DLD_CTRL_JUMP_RAMP = 0;
  localparam int DLD_CTRL_JOG_PRIO = 1;
  localparam logic [31:0] DLD_PCT_FULL = 32'h0000_03E8;
  localparam logic [15:0] DLD_RST_ZERO = 16'h0000;
  localparam logic [15:0] DLD_RST_MAX_FREQ = 16'h1388;
  localparam logic [15:0] DLD_RST_FDT_LEVEL = 16'h1388;
  localparam logic [15:0] DLD_RST_FDT_HYST = 16'h0032;
  localparam logic [15:0] DLD_RST_ARR_FREQ = 16'h1388;
  localparam logic [15:0] DLD_RST_ZERO_LEVEL = 16'h0032;
  localparam logic [15:0] DLD_RST_ZERO_DELAY = 16'h000A;
  localparam logic [15:0] DLD_RST_OC_LEVEL = 16'h07D0;
  localparam logic [15:0] DLD_RST_CUR_LEVEL = 16'h03E8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DLD_CLK_PERIOD_NS = 100;
  localparam int DLD_DELAY_UNIT_NS = 10000000;
  localparam int DLD_TICK_CYCLES = DLD_DELAY_UNIT_NS / DLD_CLK_PERIOD_NS;

  localparam logic [1:0] DLD_RESP_OKAY = 2'h0;
  localparam logic [1:0] DLD_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic jog;
    logic decel_two;
    logic accel_two;
    logic cur_arr2;
    logic cur_arr1;
    logic over_cur;
    logic zero_cur;
    logic arr2;
    logic arr1;
    logic target;
    logic freq_level_detector_two;
    logic freq_level_detector_one;
  } dld_stat_t;

  function automatic logic [15:0] dld_reset_value(input int idx);
    case (idx)
      int'(DLD_OFF_MAX_FREQ[7:2]): dld_reset_value = DLD_RST_MAX_FREQ;
      int'(DLD_OFF_LVL1_LEVEL[7:2]), int'(DLD_OFF_LVL2_LEVEL[7:2]):
        dld_reset_value = DLD_RST_FDT_LEVEL;
      int'(DLD_OFF_LVL1_HYST[7:2]), int'(DLD_OFF_LVL2_HYST[7:2]):
        dld_reset_value = DLD_RST_FDT_HYST;
      int'(DLD_OFF_ARR1_FREQ[7:2]), int'(DLD_OFF_ARR2_FREQ[7:2]):
        dld_reset_value = DLD_RST_ARR_FREQ;
      int'(DLD_OFF_ZERO_LEVEL[7:2]): dld_reset_value = DLD_RST_ZERO_LEVEL;
      int'(DLD_OFF_ZERO_DELAY[7:2]): dld_reset_value = DLD_RST_ZERO_DELAY;
      int'(DLD_OFF_OC_LEVEL[7:2]): dld_reset_value = DLD_RST_OC_LEVEL;
      int'(DLD_OFF_CUR1_LEVEL[7:2]), int'(DLD_OFF_CUR2_LEVEL[7:2]):
        dld_reset_value = DLD_RST_CUR_LEVEL;
      default: dld_reset_value = DLD_RST_ZERO;
    endcase
  endfunction : dld_reset_value

endpackage : dld_pkg

//--- rtl/dld_delay_timer.sv
// Qualifying delay timer for the current detectors
`timescale 1ns/1ns
`default_nettype none
module dld_delay_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [15:0] delay,
  output logic active_q
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic active_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!cond)
    begin
      cnt_d = 16'h0000;
    end
    else if (tick && cnt_q != 16'hFFFF)
    begin
      cnt_d = cnt_q + 16'h0001;
    end
    // Strictly longer than the delay, so a zero delay still needs one tick
    active_d = cond && (cnt_q > delay);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 16'h0000;
      active_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      active_q <= active_d;
    end
  end

  a_timer_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    !cond |=> !active_q) else $error("delay output did not drop with condition");
  a_timer_early: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_q <= delay) |=> !active_q) else $error("delay output before delay elapsed");

endmodule : dld_delay_timer
`default_nettype wire

//--- verification/dld_ctrl_reader.sv
// Control system model that reads the multi-function output terminals
`timescale 1ns/1ns
`default_nettype none
module dld_ctrl_reader
  import dld_pkg::*;
(
  input wire logic aclk,
  input wire dld_stat_t terminals,
  output dld_stat_t seen_q
);
  // Latched once a cycle; a real controller never sees mid-cycle glitches
  always_ff @(posedge aclk)
  begin
    seen_q <= terminals;
  end
endmodule : dld_ctrl_reader
`default_nettype wire

//--- verification/tb_dld_top.sv
// Self-checking testbench for the drive level detectors
`timescale 1ns/1ns
`default_nettype none
module tb_dld_top
  import dld_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wda = 32'h0, rda, rdv;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wr, bvl, arr, rvl;
  logic [1:0] brs, rrs, rsp;
  logic [15:0] rf = 16'h0, tf = 16'h0, cur = 16'h0, rfq;
  logic acc = 0, dec = 0, run = 0, m1 = 1, rbt = 0, jog = 0;
  dld_stat_t st, seen;
  int err_total = 0, n_compared = 0, cfg[24], seed = 32'hefa165e1, f, w, i;

  localparam int TICKS = 10;

  dld_top #(.TICK_CYCLES(TICKS)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wda),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brs),
    .s_axi_bvalid(bvl), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rda), .s_axi_rresp(rrs), .s_axi_rvalid(rvl),
    .s_axi_rready(rre), .ramp_freq(rf), .target_freq(tf), .out_current(cur),
    .accelerating(acc), .decelerating(dec), .running(run), .motor_one_active(m1),
    .ramp_by_terminal(rbt), .jog_request(jog), .run_freq_q(rfq), .stat_q(st));
  dld_ctrl_reader ctrl_u (.aclk(aclk), .terminals(st), .seen_q(seen));

  initial
  begin
    forever #50 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awa <= a; wda <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awr === 1'b1) begin ad = 1; awv <= 1'b0; end
      if (!wd && wr === 1'b1) begin wd = 1; wv <= 1'b0; end
    end
    while (bvl !== 1'b1) @(posedge aclk);
    r = brs;
    bre <= 1'b0;
    if (a < DLD_OFF_STATUS) cfg[a[7:2]] = int'(d[15:0]);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rvl !== 1'b1) @(posedge aclk);
    d = rda;
    r = rrs;
    rre <= 1'b0;
  endtask : axr

  // Detector outputs stand two edges after the ramp input; the reader's copy needs all three
  task automatic setf(input int fv);
    @(posedge aclk);
    rf <= 16'(fv);
    repeat (3) @(posedge aclk);
    #1;
  endtask : setf

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : wait_cyc

  function automatic logic inband(input int fv, input int c, input int wv_i);
    return (fv >= c - wv_i) && (fv <= c + wv_i);
  endfunction : inband

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Whole run is under a thousand cycles; this leaves ample slack
  initial
  begin
    #3000000;
    err_total++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    for (i = 0; i < 24; i++) cfg[i] = 0;
    cfg[1] = 5000; cfg[2] = 5000; cfg[3] = 50; cfg[4] = 5000; cfg[5] = 50; cfg[7] = 5000;
    cfg[9] = 5000; cfg[11] = 50; cfg[12] = 10; cfg[13] = 2000; cfg[15] = 1000;
    cfg[17] = 1000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 24; i++)
    begin
      axr(8'(i * 4), rdv, rsp);
      chk("reset value", rdv, 32'(cfg[i]));
    end
    axr(8'h64, rdv, rsp);
    chk("unmapped data", rdv, 32'h0000_0000);
    chk("unmapped resp", rsp, DLD_RESP_SLVERR);
    axw(DLD_OFF_STATUS, 32'h0000_FFFF, rsp);
    chk("status write", rsp, DLD_RESP_SLVERR);
    $display("test registers done");

    // Hysteresis: on above 5000, off below 4750
    setf(6000);
    chk("fdt on", {st.freq_level_detector_two, st.freq_level_detector_one}, 2'b11);
    chk("reader view", seen.freq_level_detector_one, 1'b1);
    setf(4800);
    chk("fdt held", {st.freq_level_detector_two, st.freq_level_detector_one}, 2'b11);
    setf(4700);
    chk("fdt off", {st.freq_level_detector_two, st.freq_level_detector_one}, 2'b00);
    $display("test level detectors done");

    // Random sweep of bands against the model
    // Upper lanes carry junk that must be dropped
    axw(DLD_OFF_TGT_WIDTH, 32'hABCD_0064, rsp);
    chk("write resp", rsp, DLD_RESP_OKAY);
    axr(DLD_OFF_TGT_WIDTH, rdv, rsp);
    chk("read back", rdv, 32'(cfg[6]));
    axw(DLD_OFF_ARR1_WIDTH, 32'd10, rsp);
    tf <= 16'd3000;
    for (i = 0; i < 30; i++)
    begin
      f = 2400 + ($unsigned($random(seed)) % 3000);
      if (i == 0) f = 3500;
      if (i == 1) f = 3501;
      setf(f);
      chk("target band", st.target, inband(f, 3000, cfg[6] * cfg[1] / 1000));
      chk("arrival one", st.arr1, inband(f, cfg[7], cfg[8] * cfg[1] / 1000));
      chk("arrival two", st.arr2, inband(f, cfg[9], cfg[10] * cfg[1] / 1000));
    end
    $display("test arrival bands done");

    // Jump band 2800..3200, crossed upwards then downwards
    axw(DLD_OFF_JUMP1, 32'd3000, rsp);
    axw(DLD_OFF_JUMP_BAND, 32'd200, rsp);
    for (i = 0; i < 3; i++)
    begin
      axw(DLD_OFF_CTRL, (i < 2) ? 32'h1 : 32'h0, rsp);
      acc <= (i != 1);
      dec <= (i == 1);
      setf(3100);
      chk("jump freq", rfq, (i == 0) ? 16'd3200 : (i == 1) ? 16'd2800 : 16'd3100);
    end
    $display("test jump done");

    // Ramp time selection around 3000
    axw(DLD_OFF_ACCEL_SW, 32'd3000, rsp);
    axw(DLD_OFF_DECEL_SW, 32'd3000, rsp);
    acc <= 1'b1; dec <= 1'b0;
    setf(2000);
    chk("accel two", st.accel_two, 1'b1);
    setf(4000);
    chk("accel one", st.accel_two, 1'b0);
    acc <= 1'b0; dec <= 1'b1;
    setf(4000);
    chk("decel one", st.decel_two, 1'b0);
    setf(2000);
    chk("decel two", st.decel_two, 1'b1);
    rbt <= 1'b1;
    wait_cyc(3);
    chk("terminal select", st.decel_two, 1'b0);
    rbt <= 1'b0; m1 <= 1'b0; dec <= 1'b0; acc <= 1'b1;
    wait_cyc(3);
    chk("motor two", st.accel_two, 1'b0);
    m1 <= 1'b1; acc <= 1'b0;
    $display("test ramp select done");

    // Jog priority while running
    run <= 1'b1; jog <= 1'b1;
    wait_cyc(3);
    chk("jog no prio", st.jog, 1'b0);
    axw(DLD_OFF_CTRL, 32'h2, rsp);
    wait_cyc(3);
    chk("jog prio", st.jog, 1'b1);
    // Running at 2000 below both switchovers, zero current long held
    axr(DLD_OFF_STATUS, rdv, rsp);
    chk("status word", rdv, 32'h0000_0E20);
    jog <= 1'b0;
    $display("test jog done");

    // Current detectors with ten-cycle ticks, zero delay 10 ticks
    // Current has sat at zero since reset, so lift it first to restart the timer
    cur <= 16'd51;
    wait_cyc(3);
    chk("zero off", st.zero_cur, 1'b0);
    cur <= 16'd50;
    wait_cyc(9 * TICKS);
    chk("zero early", st.zero_cur, 1'b0);
    wait_cyc(5 * TICKS);
    chk("zero late", st.zero_cur, 1'b1);
    cur <= 16'd51;
    wait_cyc(3);
    chk("zero drop", st.zero_cur, 1'b0);
    cur <= 16'd50;
    wait_cyc(6 * TICKS);
    chk("zero restart", st.zero_cur, 1'b0);
    cur <= 16'd2000;
    wait_cyc(2 * TICKS + 4);
    chk("over current", st.over_cur, 1'b1);
    axw(DLD_OFF_OC_LEVEL, 32'd0, rsp);
    wait_cyc(3 * TICKS);
    chk("over disabled", st.over_cur, 1'b0);
    axw(DLD_OFF_CUR1_WIDTH, 32'd5, rsp);
    for (i = 0; i < 4; i++)
    begin
      w = (i == 0) ? 1000 : (i == 1) ? 1005 : (i == 2) ? 1006 : 994;
      cur <= 16'(w);
      wait_cyc(3);
      chk("current one", st.cur_arr1, inband(w, cfg[15], cfg[16]));
      chk("current two", st.cur_arr2, inband(w, cfg[17], cfg[18]));
    end
    $display("test current done");
    tally_and_finish;
  end
endmodule : tb_dld_top
`default_nettype wire
